// ### rscc_pkg.sv
// constants and types shared by the reset strap configuration capture block
`default_nettype none

package rscc_pkg;

  // -------------------------------------------------------------------------
  // clock and reset sequence timing
  // -------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned RST_SEQ_NS     = 100;
  localparam int unsigned RST_SEQ_CYCLES = (RST_SEQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SEQ_CNT_W      = 5;
  localparam logic [SEQ_CNT_W-1:0] SEQ_LAST = SEQ_CNT_W'(RST_SEQ_CYCLES - 1);

  // -------------------------------------------------------------------------
  // configuration word layout
  // -------------------------------------------------------------------------
  localparam int unsigned WORD_W       = 16;
  localparam int unsigned BOOT_BIT     = 4;
  localparam int unsigned CS_LO_BIT    = 9;
  localparam int unsigned CS_HI_BIT    = 10;
  localparam int unsigned SEG_LO_BIT   = 11;
  localparam int unsigned SEG_HI_BIT   = 12;
  localparam int unsigned CLK_LO_BIT   = 13;
  localparam int unsigned CLK_MID_BIT  = 14;
  localparam int unsigned CLK_HI_BIT   = 15;
  localparam logic [WORD_W-1:0] WORD_DEFAULT = 16'hFFFF;

  // -------------------------------------------------------------------------
  // decoded field widths and encodings
  // -------------------------------------------------------------------------
  localparam int unsigned CS_W   = 3;
  localparam int unsigned CS_MAX = 5;
  localparam int unsigned SEG_W  = 4;
  localparam int unsigned SEG_MAX = 8;
  localparam int unsigned MUL_W  = 3;
  localparam int unsigned KHZ_W  = 17;

  localparam logic [CS_W-1:0]  CS_FIVE   = 3'h5;
  localparam logic [CS_W-1:0]  CS_THREE  = 3'h3;
  localparam logic [CS_W-1:0]  CS_TWO    = 3'h2;
  localparam logic [CS_W-1:0]  CS_NONE   = 3'h0;
  localparam logic [SEG_W-1:0] SEG_TWO   = 4'h2;
  localparam logic [SEG_W-1:0] SEG_FOUR  = 4'h4;
  localparam logic [SEG_W-1:0] SEG_EIGHT = 4'h8;
  localparam logic [SEG_W-1:0] SEG_NONE  = 4'h0;
  localparam logic [MUL_W-1:0] MUL_X1    = 3'h1;
  localparam logic [MUL_W-1:0] MUL_X2    = 3'h2;
  localparam logic [MUL_W-1:0] MUL_X3    = 3'h3;
  localparam logic [MUL_W-1:0] MUL_X4    = 3'h4;
  localparam logic [MUL_W-1:0] MUL_X5    = 3'h5;

  // board crystal, kHz
  localparam logic [KHZ_W-1:0] CRYSTAL_KHZ = 17'h01388;
  localparam logic [KHZ_W-1:0] CPU_KHZ_DEFAULT = 17'h04E20;

  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {ST_RESET, ST_SEQ, ST_RUN} rscc_state_t;

  typedef struct packed {
    rscc_state_t          state;
    logic [SEQ_CNT_W-1:0] cnt;
    logic                 valid;
    logic [WORD_W-1:0]    word;
    logic                 boot;
    logic [CS_W-1:0]      cs_count;
    logic [CS_MAX-1:0]    cs_en;
    logic [SEG_W-1:0]     seg_count;
    logic [MUL_W-1:0]     mult;
    logic                 direct;
    logic [KHZ_W-1:0]     cpu_khz;
  } rscc_st_t;

endpackage : rscc_pkg

`default_nettype wire

// ### rscc_cfg_if.sv
// raw configuration word and its decoded fields between capture and decoder
`default_nettype none

interface rscc_cfg_if;
  import rscc_pkg::*;

  logic [WORD_W-1:0] word;
  logic              boot;
  logic [CS_W-1:0]   cs_count;
  logic [SEG_W-1:0]  seg_count;
  logic [MUL_W-1:0]  mult;
  logic              direct;
  logic [KHZ_W-1:0]  cpu_khz;

  modport dec (input word, output boot, cs_count, seg_count, mult, direct, cpu_khz);
  modport cap (output word, input boot, cs_count, seg_count, mult, direct, cpu_khz);
endinterface : rscc_cfg_if

`default_nettype wire

// ### rscc_decode.sv
// combinational decoder of the configuration word into feature settings
`default_nettype none

module rscc_decode
(
  rscc_cfg_if.dec cfg
);
  import rscc_pkg::*;

  logic [1:0] cs_bits;
  logic [1:0] seg_bits;
  logic [1:0] clk_bits;
  logic [KHZ_W+MUL_W-1:0] prod;

  // ---------------------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------------------
  // a switch that is on pulls its pin low, so a zero bit means switch on
  always_comb
  begin
    cs_bits  = {cfg.word[CS_HI_BIT], cfg.word[CS_LO_BIT]};
    seg_bits = {cfg.word[SEG_HI_BIT], cfg.word[SEG_LO_BIT]};
    clk_bits = {cfg.word[CLK_MID_BIT], cfg.word[CLK_LO_BIT]};
    cfg.boot = ~cfg.word[BOOT_BIT];
    unique case (cs_bits)
      2'b11: cfg.cs_count = CS_FIVE;
      2'b00: cfg.cs_count = CS_THREE;
      2'b01: cfg.cs_count = CS_TWO;
      2'b10: cfg.cs_count = CS_NONE;
    endcase
    unique case (seg_bits)
      2'b11: cfg.seg_count = SEG_TWO;
      2'b00: cfg.seg_count = SEG_FOUR;
      2'b10: cfg.seg_count = SEG_EIGHT;
      2'b01: cfg.seg_count = SEG_NONE;
    endcase
    // direct drive overrides the multiplier pins
    cfg.direct = ~cfg.word[CLK_HI_BIT];
    if (cfg.direct)
    begin
      cfg.mult = MUL_X1;
    end
    else
    begin
      unique case (clk_bits)
        2'b11: cfg.mult = MUL_X4;
        2'b10: cfg.mult = MUL_X3;
        2'b01: cfg.mult = MUL_X2;
        2'b00: cfg.mult = MUL_X5;
      endcase
    end
    prod        = {{MUL_W{1'b0}}, CRYSTAL_KHZ} * {{KHZ_W{1'b0}}, cfg.mult};
    cfg.cpu_khz = prod[KHZ_W-1:0];
  end

endmodule : rscc_decode

`default_nettype wire

// ### rscc_top.sv
// reset strap configuration capture: sample, decode and hold the config word
// What this block does
// - sample all sixteen pins at reset sequence end
// - weak pullups on every pin during reset
// - bit 4 low starts the boot loader
// - bits 9-10 select chip-select output count
// - both chip-select pins high enable five
// - bits 11-12 select segment address line count
// - bits 13-15 select clock source and multiplier
// - default clock with 5 MHz crystal gives 20 MHz
`default_nettype none

module rscc_top
(
  input  wire logic                         ref_clk_i,
  input  wire logic                         rst_n_i,
  input  wire logic                         sys_rst_n_i,
  input  wire logic [rscc_pkg::WORD_W-1:0]  config_port_i,
  output logic      [rscc_pkg::WORD_W-1:0]  config_pullup_en_o,
  output logic                              config_valid_o,
  output logic      [rscc_pkg::WORD_W-1:0]  config_word_o,
  output logic                              boot_loader_select_o,
  output logic      [rscc_pkg::CS_W-1:0]    chip_select_count_o,
  output logic      [rscc_pkg::CS_MAX-1:0]  chip_select_enable_o,
  output logic      [rscc_pkg::SEG_W-1:0]   segment_line_count_o,
  output logic      [rscc_pkg::MUL_W-1:0]   clock_source_config_o,
  output logic                              clock_direct_drive_o,
  output logic      [rscc_pkg::KHZ_W-1:0]   cpu_clk_khz_o
);
  import rscc_pkg::*;

  localparam rscc_st_t ST_INIT = '{
    state:     ST_RESET,
    cnt:       '0,
    valid:     1'b0,
    word:      WORD_DEFAULT,
    boot:      1'b0,
    cs_count:  CS_FIVE,
    cs_en:     {CS_MAX{1'b1}},
    seg_count: SEG_TWO,
    mult:      MUL_X4,
    direct:    1'b0,
    cpu_khz:   CPU_KHZ_DEFAULT
  };

  rscc_st_t st_q;
  rscc_st_t st_d;

  rscc_cfg_if cfg ();

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  // thermometer mask: low 'n' outputs enabled
  function automatic logic [CS_MAX-1:0] cs_mask(input logic [CS_W-1:0] n);
    logic [CS_MAX-1:0] m;
    m = '0;
    for (int i = 0; i < CS_MAX; i++)
    begin
      m[i] = (CS_W'(i) < n);
    end
    return m;
  endfunction : cs_mask

  // ---------------------------------------------------------------------------
  // decoder sees the live pins; results only matter at the capture edge
  // ---------------------------------------------------------------------------
  assign cfg.word = config_port_i;

  rscc_decode u_decode
  (
    .cfg (cfg)
  );

  // ---------------------------------------------------------------------------
  // reset sequence and capture
  // ---------------------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    unique case (st_q.state)
      ST_RESET:
      begin
        st_d.valid = 1'b0;
        st_d.cnt   = '0;
        if (sys_rst_n_i)
        begin
          st_d.state = ST_SEQ;
        end
      end
      ST_SEQ:
      begin
        if (!sys_rst_n_i)
        begin
          st_d.state = ST_RESET;
        end
        else if (st_q.cnt == SEQ_LAST)
        begin
          // sample at the very end of the internal reset sequence
          st_d.state     = ST_RUN;
          st_d.valid     = 1'b1;
          st_d.word      = config_port_i;
          st_d.boot      = cfg.boot;
          st_d.cs_count  = cfg.cs_count;
          st_d.cs_en     = cs_mask(cfg.cs_count);
          st_d.seg_count = cfg.seg_count;
          st_d.mult      = cfg.mult;
          st_d.direct    = cfg.direct;
          st_d.cpu_khz   = cfg.cpu_khz;
        end
        else
        begin
          st_d.cnt = st_q.cnt + SEQ_CNT_W'(1);
        end
      end
      ST_RUN:
      begin
        // pins are ignored here; settings change only through a new reset
        // valid drops with the state so no edge shows stale settings as live
        if (!sys_rst_n_i)
        begin
          st_d.state = ST_RESET;
          st_d.valid = 1'b0;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_q <= ST_INIT;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  // pullups stay on through the whole sequence so open pins read high
  assign config_pullup_en_o    = {WORD_W{st_q.state != ST_RUN}};
  assign config_valid_o        = st_q.valid;
  assign config_word_o         = st_q.word;
  assign boot_loader_select_o  = st_q.boot;
  assign chip_select_count_o   = st_q.cs_count;
  assign chip_select_enable_o  = st_q.cs_en;
  assign segment_line_count_o  = st_q.seg_count;
  assign clock_source_config_o = st_q.mult;
  assign clock_direct_drive_o  = st_q.direct;
  assign cpu_clk_khz_o         = st_q.cpu_khz;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_capture_edge;
    st_q.state == ST_SEQ && sys_rst_n_i && st_q.cnt == SEQ_LAST;
  endsequence

  sequence s_release;
    $rose(sys_rst_n_i) ##0 st_q.state == ST_RESET;
  endsequence

  a_capture_word: assert property (
    s_capture_edge |=> config_valid_o && config_word_o == $past(config_port_i))
    else $error("word not captured at end of reset sequence");

  a_no_early_valid: assert property (
    s_release |-> (!config_valid_o && config_pullup_en_o == 16'hFFFF)[*8])
    else $error("valid or pullups wrong right after reset release");

  a_pullup_reset: assert property (
    !sys_rst_n_i |=> config_pullup_en_o == 16'hFFFF && !config_valid_o)
    else $error("pullups off or valid set during reset");

  a_boot_select: assert property (
    config_valid_o |-> boot_loader_select_o == !config_word_o[BOOT_BIT])
    else $error("boot loader select does not follow bit 4");

  a_cs_map: assert property (
    config_valid_o |-> chip_select_count_o ==
      ((config_word_o[10:9] == 2'b00) ? 3'h3 :
       (config_word_o[10:9] == 2'b01) ? 3'h2 :
       (config_word_o[10:9] == 2'b10) ? 3'h0 : 3'h5))
    else $error("chip select count decode wrong");

  a_cs_open_five: assert property (
    config_valid_o && config_word_o[10:9] == 2'b11 |->
      chip_select_enable_o == 5'h1F)
    else $error("open chip select pins do not enable five outputs");

  a_seg_map: assert property (
    config_valid_o |-> segment_line_count_o ==
      ((config_word_o[12:11] == 2'b00) ? 4'h4 :
       (config_word_o[12:11] == 2'b10) ? 4'h8 :
       (config_word_o[12:11] == 2'b01) ? 4'h0 : 4'h2))
    else $error("segment line count decode wrong");

  a_clk_map: assert property (
    config_valid_o |-> clock_source_config_o ==
      (!config_word_o[15] ? 3'h1 :
       (config_word_o[14:13] == 2'b10) ? 3'h3 :
       (config_word_o[14:13] == 2'b01) ? 3'h2 :
       (config_word_o[14:13] == 2'b00) ? 3'h5 : 3'h4)
      && clock_direct_drive_o == !config_word_o[15])
    else $error("clock source decode wrong");

  a_cpu_default: assert property (
    config_valid_o && config_word_o[15:13] == 3'h7 |-> cpu_clk_khz_o == 17'h04E20)
    else $error("default clock setting does not give 20 MHz");

  a_word_held: assert property (
    config_valid_o && $past(config_valid_o) |->
      $stable(config_word_o) && $stable(chip_select_count_o) &&
      $stable(cpu_clk_khz_o) && $stable(boot_loader_select_o))
    else $error("latched configuration changed outside reset");

endmodule : rscc_top

`default_nettype wire

// ### rscc_board.sv
// board switch bank model driving the configuration port pins
`default_nettype none

module rscc_board
(
  input  wire logic                        clk_i,
  input  wire logic [rscc_pkg::WORD_W-1:0] pullup_en_i,
  input  wire logic [rscc_pkg::WORD_W-1:0] switch_on_i,
  output logic      [rscc_pkg::WORD_W-1:0] pins_o
);
  import rscc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic [WORD_W-1:0] last_q;

  // a floating pin without pullup flips every cycle, never looks stable
  always_ff @(posedge clk_i)
  begin
    last_q <= pins_o;
  end

  // a closed switch pulls low and beats the weak pullup
  assign pins_o = ~switch_on_i & (pullup_en_i | ~last_q);
endmodule : rscc_board

`default_nettype wire

// ### rscc_top_tb.sv
// self-checking bench for the reset strap configuration capture block
`default_nettype none

module rscc_top_tb;
  import rscc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  typedef logic [49:0] rscc_exp_t;

  logic              ref_clk_i;
  logic              rst_n_i;
  logic              sys_rst_n_i;
  logic              valid;
  logic              valid_prev;
  logic              boot;
  logic              direct;
  logic [WORD_W-1:0] pins;
  logic [WORD_W-1:0] sw;
  logic [WORD_W-1:0] pu_en;
  logic [WORD_W-1:0] word;
  logic [CS_W-1:0]   cs_cnt;
  logic [CS_MAX-1:0] cs_en;
  logic [SEG_W-1:0]  seg_cnt;
  logic [MUL_W-1:0]  mult;
  logic [KHZ_W-1:0]  khz;
  logic [15:0]       lfsr_q;
  rscc_exp_t         got;
  rscc_exp_t         last_exp;
  rscc_exp_t         exp_q[$];
  int                failures;
  int                n_tests;

  rscc_top dut
  (
    .ref_clk_i            (ref_clk_i),
    .rst_n_i              (rst_n_i),
    .sys_rst_n_i          (sys_rst_n_i),
    .config_port_i        (pins),
    .config_pullup_en_o   (pu_en),
    .config_valid_o       (valid),
    .config_word_o        (word),
    .boot_loader_select_o (boot),
    .chip_select_count_o  (cs_cnt),
    .chip_select_enable_o (cs_en),
    .segment_line_count_o (seg_cnt),
    .clock_source_config_o(mult),
    .clock_direct_drive_o (direct),
    .cpu_clk_khz_o        (khz)
  );

  rscc_board board
  (
    .clk_i      (ref_clk_i),
    .pullup_en_i(pu_en),
    .switch_on_i(sw),
    .pins_o     (pins)
  );

  assign got = {word, boot, cs_cnt, cs_en, seg_cnt, mult, direct, khz};

  // 200 MHz clock
  initial
  begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next

  // expected settings worked out from a captured pin word
  function automatic rscc_exp_t exp_of(input logic [15:0] w);
    logic [2:0] cs;
    logic [3:0] seg;
    logic [2:0] m;
    case ({w[10], w[9]})
      2'b11:   cs = 3'h5;
      2'b00:   cs = 3'h3;
      2'b01:   cs = 3'h2;
      default: cs = 3'h0;
    endcase
    case ({w[12], w[11]})
      2'b11:   seg = 4'h2;
      2'b00:   seg = 4'h4;
      2'b10:   seg = 4'h8;
      default: seg = 4'h0;
    endcase
    case ({w[15], w[14], w[13]})
      3'b111:  m = 3'h4;
      3'b110:  m = 3'h3;
      3'b101:  m = 3'h2;
      3'b100:  m = 3'h5;
      default: m = 3'h1;
    endcase
    return {w, ~w[4], cs, 5'((8'h01 << cs) - 8'h01), seg, m, ~w[15], 17'(CRYSTAL_KHZ * m)};
  endfunction : exp_of

  task automatic chk(input rscc_exp_t g, input rscc_exp_t e);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  // system reset with switches set, then a bounded wait for the capture
  task automatic capture(input logic [15:0] s);
    int n;
    sys_rst_n_i = 1'b0;
    sw = s;
    repeat (2) @(negedge ref_clk_i);
    chk(50'(pu_en), 50'hFFFF);
    exp_q.push_back(exp_of(~s));
    last_exp = exp_of(~s);
    sys_rst_n_i = 1'b1;
    n = 0;
    while (valid !== 1'b1 && n < 40)
    begin
      @(negedge ref_clk_i);
      n++;
    end
    chk(50'(n), 50'h15);
    if (n >= 40)
      final_report();
    chk(50'(pu_en), 50'h0);
  endtask : capture

  // --------------------------------------------------------------------------
  // monitor: each new capture is compared with the oldest note
  // --------------------------------------------------------------------------
  always @(negedge ref_clk_i)
  begin
    // an unexpected capture with an empty queue always mismatches
    if (rst_n_i === 1'b1 && valid === 1'b1 && valid_prev !== 1'b1)
      chk(got, exp_q.size() > 0 ? exp_q.pop_front() : ~got);
    valid_prev = valid;
  end

  // main sequence, inputs changed at the falling edge
  initial
  begin
    rst_n_i = 1'b0;
    sys_rst_n_i = 1'b0;
    sw = 16'h0000;
    lfsr_q = 16'h0020;
    failures = 0;
    n_tests = 0;
    valid_prev = 1'b0;
    repeat (12) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    @(negedge ref_clk_i);
    capture(16'h0000);
    $display("test defaults done");
    // every code of the count and clock fields, random boot switch
    for (int i = 0; i < 16; i++)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      capture({i[3:1], i[3:0], 4'h0, lfsr_q[0], 4'h0});
    end
    $display("test field codes done");
    // pins scrambled after capture must not disturb the settings
    repeat (30)
    begin
      @(negedge ref_clk_i);
      lfsr_q = lfsr_next(lfsr_q);
      sw = lfsr_q;
    end
    chk(got, last_exp);
    $display("test hold done");
    // sequence cut short by a second system reset, then redone
    sys_rst_n_i = 1'b0;
    sw = 16'h7E00;
    repeat (2) @(negedge ref_clk_i);
    sys_rst_n_i = 1'b1;
    repeat (10) @(negedge ref_clk_i);
    capture(16'h0610);
    repeat (5) @(negedge ref_clk_i);
    chk(50'(exp_q.size()), 50'h0);
    $display("test abort done");
    final_report();
  end
endmodule : rscc_top_tb

`default_nettype wire
